// File: logic/atp_core.sv
// Configuration registers, test patterns and scrambler of the converter outputs.
`timescale 1ns/1ps
//
// Summary of operation
// - Select bit low applies fused common-mode
// - Select bit high applies register common-mode
// - Five-bit trim, reset 10, read mirror
// - Zero select bits choose fused values
// - Test enable swaps conversion for pattern
// - Code 06 flash, 04 ramp, others reserved
// - Ramp counts twelve bits on every core
// - Six-bit flash length, reset 18
// - Flash lasts four times value plus four
// - Scrambler polynomial x7 plus x6 plus 1
// - Same scrambler bit on all word bits
// - New scrambler bit every N samples
// - Scrambler control bit 0 enables sequence
// - Scrambler control bit 1 drops the signal while bit 0 is set
// - Alignment pulse restarts the scrambler sequence
// - Read-only part code in master space
// - Channel select routes core, all, master
module atp_core
    import atp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        spi_sclk,
    input  wire logic        spi_csn,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    input  wire logic        sync_pulse,
    input  wire logic [4:0]  fuse_cm_code,
    output logic [4:0]       input_common_mode_code,
    input  wire logic        conv_valid,
    output logic             conv_ready,
    input  wire logic [55:0] conv_words,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [55:0]      out_words
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       sclk_s;       // Clock pin synchroniser and history
        logic [1:0]       csn_s;        // Select pin synchroniser
        logic [1:0]       mosi_s;       // Data pin synchroniser
        logic [2:0]       sync_s;       // Alignment pin synchroniser and history
        logic [4:0]       fuse_s1;      // Fused code, first stage
        logic [4:0]       fuse_s2;      // Fused code, second stage
        logic [4:0]       bit_cnt;      // Bits taken in this frame
        logic [22:0]      sh_in;        // Incoming frame bits
        logic [15:0]      sh_out;       // Outgoing read data
        logic             miso;         // Serial read bit
        logic             miso_oe;      // Serial read drive
        logic [2:0]       chan_sel;     // Access routing
        logic [2:0]       fuse_sel;     // Fuse override selects
        logic [4:0]       cm_trim;      // Register common-mode code
        logic [4:0]       cm_applied;   // Code in use
        logic [3:0][6:0]  test_ctrl;    // Per-core test control
        logic [3:0][1:0]  scr_ctrl;     // Per-core scrambler control
        logic [3:0][5:0]  flash_len;    // Per-core flash length
        logic [11:0]      ramp;         // Shared ramp value
        logic [3:0][7:0]  flash_cnt;    // Per-core flash phase counter
        logic [3:0]       flash_lvl;    // Per-core flash level
        logic [6:0]       lfsr;         // Scrambler shift register
        logic [4:0]       step_cnt;     // Samples since last scrambler step
        logic             out_valid;    // Output stage full
        logic [55:0]      out_words;    // Output stage words
    } atp_core_t;

    atp_core_t   st;
    atp_core_t   next_st;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [55:0] fifo_out_data;
    logic [55:0] word_bus;          // Words offered to the FIFO
    logic        take;              // Sample accepted this cycle

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Parity over the twelve data bits
    function automatic logic parity12(input logic [11:0] d);
        parity12 = ^d;
    endfunction

    // Pattern word with parity and an in-range flag set
    function automatic logic [13:0] pattern_word(input logic [11:0] d);
        pattern_word = {1'b1, parity12(d), d};
    endfunction

    // Flash phase limit, one less than four times length plus four
    function automatic logic [7:0] flash_limit(input logic [5:0] len);
        flash_limit = {len, 2'b11};
    endfunction

    // Register read decode for the current routing
    function automatic logic [15:0] read_reg(input atp_core_t s, input logic [6:0] a);
        logic [1:0] c;
        logic       core_sp;
        logic       mstr;
        c        = s.chan_sel[1:0];
        core_sp  = (s.chan_sel <= ATP_SEL_ALL);
        mstr     = (s.chan_sel == ATP_SEL_MASTER);
        read_reg = 16'h0000;
        // Broadcast reads answer from core A
        if (s.chan_sel == ATP_SEL_ALL) begin
            c = 2'h0;
        end
        if (a == ATP_ADDR_CHAN_SEL) begin
            read_reg = {13'h0, s.chan_sel};
        end else if (mstr) begin
            case (a)
                ATP_ADDR_PART_ID:  read_reg = ATP_PART_ID;
                ATP_ADDR_FUSE_SEL: read_reg = {13'h0, s.fuse_sel};
                ATP_ADDR_CM_TRIM:  read_reg = {11'h0, s.cm_trim};
                ATP_ADDR_CM_RB:    read_reg = {11'h0, s.cm_trim};
                default:           read_reg = 16'h0000;
            endcase
        end else if (core_sp) begin
            case (a)
                ATP_ADDR_TEST:  read_reg = {9'h0, s.test_ctrl[c]};
                ATP_ADDR_SCR:   read_reg = {14'h0, s.scr_ctrl[c]};
                ATP_ADDR_FLASH: read_reg = {10'h0, s.flash_len[c]};
                default:        read_reg = 16'h0000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Pattern and scrambler path for offered words
    // ------------------------------------------------------------
    always_comb begin
        logic [13:0] w;
        logic [5:0]  mode;
        logic        prbs;
        w        = '0;
        mode     = '0;
        prbs     = st.lfsr[6];
        word_bus = '0;
        for (int i = 0; i < ATP_CORES; i++) begin
            w    = conv_words[i*ATP_WORD_BITS +: ATP_WORD_BITS];
            mode = st.test_ctrl[i][ATP_TEST_MODE_LSB +: 6];
            // Reserved codes fall through to conversion data
            if (st.test_ctrl[i][ATP_TEST_EN_BIT]) begin
                if (mode == ATP_MODE_FLASH) begin
                    w = pattern_word({12{st.flash_lvl[i]}});
                end else if (mode == ATP_MODE_RAMP) begin
                    w = pattern_word(st.ramp);
                end
            end
            if (st.scr_ctrl[i][ATP_SCR_EN_BIT]) begin
                if (st.scr_ctrl[i][ATP_SCR_ONLY_BIT]) begin
                    w = '0;
                end
                w = w ^ {14{prbs}};
            end
            word_bus[i*ATP_WORD_BITS +: ATP_WORD_BITS] = w;
        end
    end

    assign take = conv_valid && fifo_in_ready;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        sclk_rise;
        logic        sclk_fall;
        logic        align;
        logic        wr_now;
        logic [6:0]  addr;
        logic [15:0] wdata;
        next_st   = st;
        sclk_rise = st.sclk_s[1] && !st.sclk_s[2];
        sclk_fall = !st.sclk_s[1] && st.sclk_s[2];
        align     = st.sync_s[1] && !st.sync_s[2];
        wr_now    = 1'b0;
        addr      = st.sh_in[21:15];
        wdata     = {st.sh_in[14:0], st.mosi_s[1]};

        // Pin synchronisers; second stages are read, and clock and alignment also read the third as edge history
        next_st.sclk_s  = {st.sclk_s[1:0], spi_sclk};
        next_st.csn_s   = {st.csn_s[0], spi_csn};
        next_st.mosi_s  = {st.mosi_s[0], spi_mosi};
        next_st.sync_s  = {st.sync_s[1:0], sync_pulse};
        next_st.fuse_s1 = fuse_cm_code;
        next_st.fuse_s2 = st.fuse_s1;

        // Serial port: idle select clears the frame
        if (st.csn_s[1]) begin
            next_st.bit_cnt = '0;
            next_st.miso_oe = 1'b0;
            next_st.miso    = 1'b0;
        end else begin
            next_st.miso_oe = 1'b1;
            if (sclk_rise && (st.bit_cnt <= ATP_CNT_LAST)) begin
                next_st.sh_in   = {st.sh_in[21:0], st.mosi_s[1]};
                next_st.bit_cnt = st.bit_cnt + 1'b1;
                // Header complete: read data ready for the next falling edge
                if (st.bit_cnt == ATP_CNT_HDR - 1'b1) begin
                    next_st.sh_out = read_reg(st, {st.sh_in[5:0], st.mosi_s[1]});
                end
                // Last bit of a write frame commits it
                if ((st.bit_cnt == ATP_CNT_LAST) && !st.sh_in[22]) begin
                    wr_now = 1'b1;
                end
            end
            if (sclk_fall && (st.bit_cnt >= ATP_CNT_HDR)) begin
                next_st.miso   = st.sh_out[15];
                next_st.sh_out = {st.sh_out[14:0], 1'b0};
            end
        end

        // Register writes routed by the channel select
        if (wr_now) begin
            if (addr == ATP_ADDR_CHAN_SEL) begin
                next_st.chan_sel = wdata[2:0];
            end else if (st.chan_sel == ATP_SEL_MASTER) begin
                case (addr)
                    ATP_ADDR_FUSE_SEL: next_st.fuse_sel = wdata[2:0];
                    ATP_ADDR_CM_TRIM:  next_st.cm_trim  = wdata[4:0];
                    default:           next_st.cm_trim  = st.cm_trim;
                endcase
            end else if (st.chan_sel <= ATP_SEL_ALL) begin
                for (int i = 0; i < ATP_CORES; i++) begin
                    // Broadcast reaches every core, else only the chosen one
                    if ((st.chan_sel == ATP_SEL_ALL) || (st.chan_sel[1:0] == 2'(i))) begin
                        case (addr)
                            ATP_ADDR_TEST:  next_st.test_ctrl[i] = wdata[6:0];
                            ATP_ADDR_SCR:   next_st.scr_ctrl[i]  = wdata[1:0];
                            ATP_ADDR_FLASH: next_st.flash_len[i] = wdata[5:0];
                            default:        next_st.flash_len[i] = st.flash_len[i];
                        endcase
                    end
                end
            end
        end

        // Common-mode source: fused code unless the select bit is set
        if (st.fuse_sel[ATP_FUSE_CM_BIT]) begin
            next_st.cm_applied = st.cm_trim;
        end else begin
            next_st.cm_applied = st.fuse_s2;
        end

        // Pattern generators advance per accepted sample
        if (align) begin
            next_st.ramp      = '0;
            next_st.flash_cnt = '0;
            next_st.flash_lvl = '0;
            next_st.lfsr      = ATP_LFSR_SEED;
            next_st.step_cnt  = '0;
        end else if (take) begin
            next_st.ramp = st.ramp + 1'b1;
            for (int i = 0; i < ATP_CORES; i++) begin
                if (st.flash_cnt[i] >= flash_limit(st.flash_len[i])) begin
                    next_st.flash_cnt[i] = '0;
                    next_st.flash_lvl[i] = !st.flash_lvl[i];
                end else begin
                    next_st.flash_cnt[i] = st.flash_cnt[i] + 1'b1;
                end
            end
            if (st.step_cnt >= ATP_SCR_STEP - 1'b1) begin
                next_st.step_cnt = '0;
                next_st.lfsr = {st.lfsr[5:0], st.lfsr[6] ^ st.lfsr[5]};
            end else begin
                next_st.step_cnt = st.step_cnt + 1'b1;
            end
        end

        // Registered output stage drained by the capturing side
        if (!st.out_valid || out_ready) begin
            next_st.out_valid = fifo_out_valid;
            if (fifo_out_valid) begin
                next_st.out_words = fifo_out_data;
            end
        end
    end

    assign fifo_out_ready = !st.out_valid || out_ready;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st            <= '0;
            st.sclk_s     <= '0;
            st.csn_s      <= 2'b11;
            st.chan_sel   <= ATP_RST_CHAN_SEL;
            st.fuse_sel   <= ATP_RST_FUSE_SEL;
            st.cm_trim    <= ATP_RST_CM_TRIM;
            st.test_ctrl  <= {ATP_CORES{ATP_RST_TEST}};
            st.scr_ctrl   <= {ATP_CORES{ATP_RST_SCR}};
            st.flash_len  <= {ATP_CORES{ATP_RST_FLASH}};
            st.lfsr       <= ATP_LFSR_SEED;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Word buffer
    // ------------------------------------------------------------
    atp_fifo #(
        .WIDTH (ATP_BUS_BITS),
        .DEPTH (ATP_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (conv_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (word_bus),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Back-pressure reaches the converter side directly
    assign conv_ready             = fifo_in_ready;
    assign spi_miso               = st.miso;
    assign spi_miso_oe            = st.miso_oe;
    assign input_common_mode_code = st.cm_applied;
    assign out_valid              = st.out_valid;
    assign out_words              = st.out_words;

endmodule

// File: logic/atp_pkg.sv
// Constants and field layout shared by the test-pattern and trim logic.
package atp_pkg;

    // ------------------------------------------------------------
    // Serial configuration port framing
    // ------------------------------------------------------------
    localparam int unsigned ATP_FRAME_BITS = 24;      // Read flag, 7 address, 16 data
    localparam int unsigned ATP_ADDR_BITS  = 8;       // Header length in bits
    localparam logic [4:0]  ATP_CNT_HDR    = 5'h08;   // Count after the header
    localparam logic [4:0]  ATP_CNT_LAST   = 5'h17;   // Count at the last data bit

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ATP_ADDR_PART_ID  = 7'h00;
    localparam logic [6:0] ATP_ADDR_CHAN_SEL = 7'h01;
    localparam logic [6:0] ATP_ADDR_FUSE_SEL = 7'h16;
    localparam logic [6:0] ATP_ADDR_CM_TRIM  = 7'h1b;
    localparam logic [6:0] ATP_ADDR_TEST     = 7'h5d;
    localparam logic [6:0] ATP_ADDR_SCR      = 7'h5f;
    localparam logic [6:0] ATP_ADDR_FLASH    = 7'h69;
    localparam logic [6:0] ATP_ADDR_CM_RB    = 7'h6f;

    // ------------------------------------------------------------
    // Channel select codes
    // ------------------------------------------------------------
    localparam logic [2:0] ATP_SEL_CORE_D = 3'h3;     // Highest single-core code
    localparam logic [2:0] ATP_SEL_ALL    = 3'h4;
    localparam logic [2:0] ATP_SEL_MASTER = 3'h7;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned ATP_FUSE_CM_BIT   = 1;    // Common-mode source select
    localparam int unsigned ATP_TEST_EN_BIT   = 0;    // Test enable
    localparam int unsigned ATP_TEST_MODE_LSB = 1;    // Six-bit pattern code
    localparam int unsigned ATP_SCR_EN_BIT    = 0;
    localparam int unsigned ATP_SCR_ONLY_BIT  = 1;

    localparam logic [2:0] ATP_RST_CHAN_SEL = 3'h0;
    localparam logic [2:0] ATP_RST_FUSE_SEL = 3'h0;
    localparam logic [4:0] ATP_RST_CM_TRIM  = 5'h10;
    localparam logic [6:0] ATP_RST_TEST     = 7'h00;
    localparam logic [1:0] ATP_RST_SCR      = 2'h0;
    localparam logic [5:0] ATP_RST_FLASH    = 6'h18;

    // Arbitrary neutral identification value
    localparam logic [15:0] ATP_PART_ID = 16'h0a5a;

    // ------------------------------------------------------------
    // Pattern codes and pattern-generator constants
    // ------------------------------------------------------------
    localparam logic [5:0] ATP_MODE_FLASH = 6'h06;
    localparam logic [5:0] ATP_MODE_RAMP  = 6'h04;
    localparam logic [6:0] ATP_LFSR_SEED  = 7'h7f;
    localparam logic [4:0] ATP_SCR_STEP   = 5'h01;    // Samples per scrambler bit, 1..31

    // Output word layout: 12 data bits, parity, in-range
    localparam int unsigned ATP_DATA_BITS = 12;
    localparam int unsigned ATP_WORD_BITS = 14;
    localparam int unsigned ATP_CORES     = 4;
    localparam int unsigned ATP_BUS_BITS  = 56;
    localparam int unsigned ATP_FIFO_DEPTH = 8;

endpackage

// File: logic/atp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module atp_fifo #(
    parameter int unsigned WIDTH = 56,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int unsigned AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // Storage words
        logic [AW-1:0]               wr;    // Write index
        logic [AW-1:0]               rd;    // Read index
        logic [AW:0]                 cnt;   // Words held
        logic                        room;  // Space for one more word
    } atp_fifo_t;

    atp_fifo_t st;
    atp_fifo_t next_st;
    logic      push;
    logic      pop;

    // Flags come from the held count, so full and empty are exact;
    // ready is registered from the count held after this edge
    assign in_ready  = st.room;
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rd];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        push    = in_valid && in_ready;
        pop     = out_valid && out_ready;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
        end
        // Simultaneous push and pop leaves the count alone
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        // Looking one count ahead keeps ready off any gate path
        next_st.room = (next_st.cnt != (AW+1)'(DEPTH));
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st      <= '0;
            st.room <= 1'b1;    // Empty after reset, so room
        end else begin
            st <= next_st;
        end
    end

endmodule

// File: tb/atp_core_checker.sv
// Port-level assertions for the test-pattern and trim logic.
`timescale 1ns/1ps
module atp_core_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        spi_sclk,
    input wire logic        spi_csn,
    input wire logic        spi_miso,
    input wire logic        spi_miso_oe,
    input wire logic [4:0]  fuse_cm_code,
    input wire logic [4:0]  input_common_mode_code,
    input wire logic        conv_ready,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [55:0] out_words
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_words); endproperty
    a_hold: assert property (p_hold) else $error("held word changed");
    property p_oe_off; spi_csn [*5] |-> !spi_miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven idle");
    property p_oe_on; $fell(spi_csn) |-> ##[2:4] spi_miso_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven");
    // Applied trim moves only through a frame or a fuse change
    property p_cm; (spi_csn && $stable(fuse_cm_code)) [*8] |-> $stable(input_common_mode_code);
    endproperty
    a_cm: assert property (p_cm) else $error("trim moved idle");
    property p_miso; spi_sclk [*4] |-> $stable(spi_miso); endproperty
    a_miso: assert property (p_miso) else $error("miso moved high");
    property p_rst; $fell(rst) |-> !out_valid && !spi_miso_oe && conv_ready; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_empty; !out_valid [*3] |-> conv_ready; endproperty
    a_empty: assert property (p_empty) else $error("empty but refusing");
    property p_room;
        $rose(conv_ready) |-> $past(out_valid && out_ready) || $past(out_valid && out_ready, 2);
    endproperty
    a_room: assert property (p_room) else $error("room without pop");
endmodule
bind atp_core atp_core_checker chk_u (.ref_clk, .rst, .spi_sclk, .spi_csn, .spi_miso,
    .spi_miso_oe, .fuse_cm_code, .input_common_mode_code, .conv_ready, .out_valid,
    .out_ready, .out_words);

// File: tb/atp_capture_model.sv
// Capture-side model that takes output words promptly, slowly or not at all.
`timescale 1ns/1ps
module atp_capture_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic stop,
    output logic      out_ready
);
    logic ph; // Alternates so slow mode accepts every other cycle
    // Ready changes only just after an edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ph        <= 1'b0;
            out_ready <= 1'b0;
        end else begin
            ph        <= ~ph;
            out_ready <= !stop && (!slow || ph);
        end
    end
endmodule

// File: tb/tb_atp_core.sv
// Self-checking bench for the test-pattern and trim logic.
`timescale 1ns/1ps
module tb_atp_core;
    import atp_pkg::*;
    localparam logic [55:0] W = 56'h0123456789abcd; // Converter sample
    logic        ref_clk, rst, spi_sclk, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
    logic        sync_pulse, conv_valid, conv_ready, out_valid, out_ready, slow, stop;
    logic [4:0]  fuse_cm_code, input_common_mode_code;
    logic [55:0] conv_words, out_words;
    logic [55:0] cap[$]; // Words taken by the capture side
    int          n_mismatch, n_tests;
    atp_core dut_u (.ref_clk, .rst, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso, .spi_miso_oe,
        .sync_pulse, .fuse_cm_code, .input_common_mode_code, .conv_valid, .conv_ready,
        .conv_words, .out_valid, .out_ready, .out_words);
    atp_capture_model cap_u (.ref_clk, .rst, .slow, .stop, .out_ready);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (out_valid && out_ready) cap.push_back(out_words);
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task complete_run;
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [55:0] s, input logic [55:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    // Serial frame; sclk halves of 5 cycles exceed the synchroniser minimum
    task spi(input logic r, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
        logic [23:0] f;
        f = {r, a, d};
        spi_csn = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi = f[i];
            cyc(5);
            q = {q[14:0], spi_miso};
            spi_sclk = 1'b1;
            cyc(5);
            spi_sclk = 1'b0;
        end
        spi_csn = 1'b1;
        cyc(5);
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] q;
        spi(1'b0, a, d, q);
    endtask
    task rd(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] q;
        spi(1'b1, a, 16'h0000, q);
        chk("register", q, e);
    endtask
    task sync_cores;
        sync_pulse = 1'b1;
        cyc(4);
        sync_pulse = 1'b0;
        cyc(4);
    endtask
    // Waits, bounded, until n words have reached the capture side
    task drain(input int n);
        for (int t = 0; t < 400 && cap.size() < n; t++) cyc(1);
        if (cap.size() != n) begin
            n_mismatch++;
            complete_run;
        end
    endtask
    task send(input int n, input logic [55:0] w);
        int k;
        logic r;
        k = 0;
        cap.delete();
        conv_words = w;
        conv_valid = 1'b1;
        for (int t = 0; t < 400 && k < n; t++) begin
            r = conv_ready;
            cyc(1);
            k += r;
        end
        conv_valid = 1'b0;
        drain(n);
    endtask
    task t_trim;
        rd(7'h69, 16'h0018);
        rd(7'h5f, 16'h0000);
        chk("cm", input_common_mode_code, 5'h05);
        wr(7'h01, 16'h0007);
        rd(7'h1b, 16'h0010);
        rd(7'h30, 16'h0000);
        rd(ATP_ADDR_PART_ID, ATP_PART_ID);
        wr(7'h16, 16'h0002);
        wr(7'h1b, 16'h0007);
        wr(7'h6f, 16'h001f);
        rd(7'h6f, 16'h0007);
        chk("cm", input_common_mode_code, 5'h07);
        wr(7'h16, 16'h0000);
        chk("cm", input_common_mode_code, 5'h05);
        wr(7'h01, 16'h0004);
    endtask
    task t_pass;
        logic [15:0] v[3] = '{16'h0008, 16'h0005, 16'h0071}; // Off, then reserved codes
        for (int i = 0; i < 3; i++) begin
            wr(7'h5d, v[i]);
            send(3, W);
            foreach (cap[k]) chk("normal", cap[k], W);
        end
    endtask
    task t_ramp;
        wr(7'h5d, 16'h0009);
        sync_cores;
        slow = 1'b1;
        send(10, '0);
        slow = 1'b0;
        foreach (cap[k]) for (int c = 0; c < 4; c++) begin
            chk("ramp", cap[k][14*c +: 14], {1'b1, ^12'(k), 12'(k)});
        end
    endtask
    task t_flash;
        logic lv;
        wr(7'h69, 16'h0001);
        rd(7'h69, 16'h0001);
        wr(7'h5d, 16'h000d);
        sync_cores;
        send(20, '0);
        foreach (cap[k]) begin
            lv = 1'((k / 8) % 2);
            chk("flash", cap[k], {4{1'b1, 1'b0, {12{lv}}}});
        end
        wr(7'h5d, 16'h0000);
    endtask
    task t_scr;
        logic [6:0] l;
        logic [1:0] m;
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 2'h3 : {1'b0, i == 1};
            wr(7'h5f, {14'h0, m});
            sync_cores;
            send(16, W);
            l = ATP_LFSR_SEED;
            foreach (cap[k]) begin
                chk("scrambled", cap[k], (m[1] ? '0 : W) ^ {56{m[0] & l[6]}});
                l = {l[5:0], l[6] ^ l[5]};
            end
        end
    endtask
    task t_fifo;
        int k;
        logic r;
        k = 0;
        cap.delete();
        stop = 1'b1;
        conv_valid = 1'b1;
        repeat (30) begin
            r = conv_ready;
            cyc(1);
            k += r;
        end
        conv_valid = 1'b0;
        chk("fill", 56'(k), 56'(ATP_FIFO_DEPTH + 1));
        stop = 1'b0;
        drain(ATP_FIFO_DEPTH + 1);
    endtask
    initial begin
        {spi_sclk, spi_mosi, sync_pulse, conv_valid, slow, stop} = '0;
        {n_mismatch, n_tests} = '0;
        spi_csn = 1'b1;
        rst = 1'b1;
        conv_words = '0;
        fuse_cm_code = 5'h05;
        cyc(20);
        rst = 1'b0;
        cyc(5);
        t_trim;
        t_pass;
        t_ramp;
        t_flash;
        t_scr;
        t_fifo;
        complete_run;
    end
endmodule
